// [core/cpu_general_register_file.sv]
// Purpose: eight 32-bit general registers for the CPU datapath, plus AXI4-Lite view
// Assumes: one clock, synchronous active-low reset, datapath signals synchronous
// Notes: register contents carry no reset value; software loads the stack word first
//
// Summary of operation
// - eight alike 32-bit registers, each usable for addresses or data
// - data accesses may be 32, 16 or 8 bits wide
// - each register splits into two separately addressed 16-bit halves
// - the low half splits into separately addressed high and low bytes
// - each access picks register and width on its own, no coupling
// - register 7 is also the stack word, adjusted implicitly by stack sequences
// - control registers live elsewhere; besides the general registers this file holds only the bus lock control word and a status word
// - the upper 16-bit half is the extended register, usable alone
// - reset leaves register contents untouched; software loads the stack first
`timescale 1ns/1ps
`include "regfile_params.svh"
`default_nettype none

module cpu_general_register_file
(
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// datapath read ports
	input  wire regfile_pkg::rd_req_type    rd_a,
	input  wire regfile_pkg::rd_req_type    rd_b,
	output logic [31:0]                     rd_a_data,
	output logic [31:0]                     rd_b_data,
	output logic                            rd_valid,
	// datapath write port
	input  wire regfile_pkg::wr_req_type    wr,
	// implicit stack adjustment
	input  wire regfile_pkg::stack_req_type stack_req,
	output logic [31:0]                     stack_top_ptr,
	output logic                            stack_loaded,
	// axi4-lite write address
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [`ADDR_W-1:0]         s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	// axi4-lite write response
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	// axi4-lite read address
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [`ADDR_W-1:0]         s_axi_araddr,
	// axi4-lite read data
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp
);

	// eight general words, no reset: contents survive reset unchanged
	logic [31:0]              regs [`GP_COUNT];

	logic                     bus_lock;
	logic                     aw_held;
	logic                     w_held;
	logic [`ADDR_W-1:0]       aw_addr;
	logic [31:0]              w_data;
	logic [3:0]               w_strb;
	logic [2:0]               bus_idx;
	logic                     bus_is_gp;
	logic                     bus_conflict;
	logic                     bus_do;
	logic                     bus_gp_write;
	logic                     stack_adj;
	logic [31:0]              stack_delta;
	logic [1:0]               next_bresp;
	logic [2:0]               rd_idx_bus;

	// replace only the bits that the selected view covers
	function automatic logic [31:0] merge_field
	(
		input logic [31:0]             old,
		input logic [31:0]             val,
		input regfile_pkg::gp_sel_type sel
	);
		logic [31:0] r;
		r = old;
		case (sel)
			regfile_pkg::sel_long:     r = val;
			regfile_pkg::sel_ext_half: r[`EXT_HI:`EXT_LO] = val[`LOH_HI:`LOH_LO];
			regfile_pkg::sel_lo_half:  r[`LOH_HI:`LOH_LO] = val[`LOH_HI:`LOH_LO];
			regfile_pkg::sel_hi_byte:  r[`HB_HI:`HB_LO] = val[`LB_HI:`LB_LO];
			regfile_pkg::sel_lo_byte:  r[`LB_HI:`LB_LO] = val[`LB_HI:`LB_LO];
			default:                   r = old;
		endcase
		return r;
	endfunction : merge_field

	// the selected view, right-aligned and zero-extended
	function automatic logic [31:0] pick_field
	(
		input logic [31:0]             word,
		input regfile_pkg::gp_sel_type sel
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (sel)
			regfile_pkg::sel_long:     r = word;
			regfile_pkg::sel_ext_half: r[`LOH_HI:`LOH_LO] = word[`EXT_HI:`EXT_LO];
			regfile_pkg::sel_lo_half:  r[`LOH_HI:`LOH_LO] = word[`LOH_HI:`LOH_LO];
			regfile_pkg::sel_hi_byte:  r[`LB_HI:`LB_LO] = word[`HB_HI:`HB_LO];
			regfile_pkg::sel_lo_byte:  r[`LB_HI:`LB_LO] = word[`LB_HI:`LB_LO];
			default:                   r = 32'h0000_0000;
		endcase
		return r;
	endfunction : pick_field

	// byte-lane merge for bus writes
	function automatic logic [31:0] strobe_merge
	(
		input logic [31:0] old,
		input logic [31:0] val,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction : strobe_merge

	// bus write decode; a clash with the datapath on the same word waits for as long as the clash lasts
	assign bus_idx      = aw_addr[`GP_IDX_HI:`GP_IDX_LO];
	assign bus_is_gp    = (aw_addr <= `OFS_GP_LAST) && (aw_addr[1:0] == 2'h0);
	assign bus_conflict = bus_is_gp && !bus_lock &&
		((wr.en && (wr.op.idx == bus_idx)) ||
		(stack_req.en && (bus_idx == `STACK_IDX)));
	assign bus_do       = aw_held && w_held && !bus_conflict;
	assign bus_gp_write = bus_do && bus_is_gp && !bus_lock;

	// an explicit write to the stack word overrides the implicit adjustment
	assign stack_adj   = stack_req.en && !(wr.en && (wr.op.idx == `STACK_IDX));
	assign stack_delta = {{24{stack_req.delta[7]}}, stack_req.delta};

	// register array: datapath write beats stack adjust beats bus
	always_ff @(posedge aclk)
	begin
		if (bus_gp_write)
		begin
			regs[bus_idx] <= strobe_merge(regs[bus_idx], w_data, w_strb);
		end
		if (stack_adj)
		begin
			regs[`STACK_IDX] <= regs[`STACK_IDX] + stack_delta;
		end
		if (wr.en)
		begin
			regs[wr.op.idx] <= merge_field(regs[wr.op.idx], wr.data, wr.op.sel);
		end
	end
	assign stack_top_ptr = regs[`STACK_IDX];

	// datapath reads, registered, independent views
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_a_data <= 32'h0000_0000;
			rd_b_data <= 32'h0000_0000;
			rd_valid  <= 1'h0;
		end
		else
		begin
			rd_valid <= rd_a.en || rd_b.en;
			if (rd_a.en)
			begin
				rd_a_data <= pick_field(regs[rd_a.op.idx], rd_a.op.sel);
			end
			if (rd_b.en)
			begin
				rd_b_data <= pick_field(regs[rd_b.op.idx], rd_b.op.sel);
			end
		end
	end

	// flags that the stack word has been loaded since reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stack_loaded <= 1'h0;
		end
		else if ((wr.en && (wr.op.idx == `STACK_IDX)) ||
			(bus_gp_write && (bus_idx == `STACK_IDX)))
		begin
			stack_loaded <= 1'h1;
		end
	end

	// write address and data holding
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'h0;
			w_held  <= 1'h0;
			aw_addr <= `OFS_GP_FIRST;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'h1;
				aw_addr <= s_axi_awaddr;
			end
			else if (bus_do)
			begin
				aw_held <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'h1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (bus_do)
			begin
				w_held <= 1'h0;
			end
		end
	end

	// write response code
	always_comb
	begin
		next_bresp = `RESP_SLVERR;
		if (bus_is_gp)
		begin
			next_bresp = bus_lock ? `RESP_SLVERR : `RESP_OKAY;
		end
		else if ((aw_addr == `OFS_CTRL) || (aw_addr == `OFS_STATUS))
		begin
			next_bresp = `RESP_OKAY;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= `RESP_OKAY;
		end
		else if (bus_do)
		begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp  <= next_bresp;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'h0;
		end
	end

	// control word: lock refuses software writes to the general words
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_lock <= `CTRL_RESET;
		end
		else if (bus_do && (aw_addr == `OFS_CTRL) && w_strb[0])
		begin
			bus_lock <= w_data[`CTRL_LOCK_BIT];
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx_bus    = s_axi_araddr[`GP_IDX_HI:`GP_IDX_LO];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'h0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'h1;
			s_axi_rresp  <= `RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			if ((s_axi_araddr <= `OFS_GP_LAST) && (s_axi_araddr[1:0] == 2'h0))
			begin
				s_axi_rdata <= regs[rd_idx_bus];
			end
			else if (s_axi_araddr == `OFS_CTRL)
			begin
				s_axi_rdata[`CTRL_LOCK_BIT] <= bus_lock;
			end
			else if (s_axi_araddr == `OFS_STATUS)
			begin
				s_axi_rdata[`STATUS_LOAD_BIT] <= stack_loaded;
			end
			else
			begin
				s_axi_rresp <= `RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'h0;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_long_write: assert property (wr.en && wr.op.sel == regfile_pkg::sel_long
		|=> regs[$past(wr.op.idx)] === $past(wr.data))
		else $error("long write not stored");
	chk_byte_low_keep: assert property (wr.en && wr.op.sel == regfile_pkg::sel_lo_byte
		|=> regs[$past(wr.op.idx)][31:8] === $past(regs[wr.op.idx][31:8]) &&
		regs[$past(wr.op.idx)][7:0] === $past(wr.data[7:0]))
		else $error("low byte write disturbed other bits");
	chk_byte_high_place: assert property (wr.en && wr.op.sel == regfile_pkg::sel_hi_byte
		|=> regs[$past(wr.op.idx)][15:8] === $past(wr.data[7:0]) &&
		regs[$past(wr.op.idx)][7:0] === $past(regs[wr.op.idx][7:0]))
		else $error("high byte write misplaced");
	chk_ext_half: assert property (wr.en && wr.op.sel == regfile_pkg::sel_ext_half
		|=> regs[$past(wr.op.idx)][31:16] === $past(wr.data[15:0]) &&
		regs[$past(wr.op.idx)][15:0] === $past(regs[wr.op.idx][15:0]))
		else $error("extended half write wrong");
	chk_read_view: assert property (rd_b.en && rd_b.op.sel == regfile_pkg::sel_ext_half
		|=> rd_valid && rd_b_data[31:16] == 16'h0000 &&
		rd_b_data[15:0] === $past(regs[rd_b.op.idx][31:16]))
		else $error("extended half read wrong");
	chk_stack_adjust: assert property (stack_req.en && !wr.en
		|=> stack_top_ptr === $past(stack_top_ptr) + $past(stack_delta))
		else $error("stack adjust wrong");
	chk_stack_loaded: assert property (!stack_loaded && wr.en && wr.op.idx == `STACK_IDX
		|=> stack_loaded ##1 stack_loaded)
		else $error("stack load not flagged");
	chk_bus_lock: assert property (s_axi_bvalid && bus_is_gp && bus_lock
		|-> s_axi_bresp == `RESP_SLVERR)
		else $error("locked write not refused");
	chk_read_hold: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read response not raised");

endmodule : cpu_general_register_file

`default_nettype wire

// [core/regfile_params.svh]
// Purpose: constants for the general register file and its register bus
// Assumes: 32-bit AXI4-Lite data, 6-bit byte address
// Notes: field positions name the halves and bytes of one register word
`ifndef REGFILE_PARAMS_SVH
`define REGFILE_PARAMS_SVH

`define GP_COUNT        8
`define STACK_IDX       3'h7
`define EXT_HI          31
`define EXT_LO          16
`define LOH_HI          15
`define LOH_LO          0
`define HB_HI           15
`define HB_LO           8
`define LB_HI           7
`define LB_LO           0

`define ADDR_W          6
`define OFS_GP_FIRST    6'h00
`define OFS_GP_LAST     6'h1C
`define OFS_CTRL        6'h20
`define OFS_STATUS      6'h24
`define GP_IDX_HI       4
`define GP_IDX_LO       2

`define CTRL_LOCK_BIT   0
`define CTRL_RESET      1'h0
`define STATUS_LOAD_BIT 0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// [core/regfile_pkg.sv]
// Purpose: types carried between the datapath and the register file
// Assumes: nothing beyond the constants header
// Notes: operand selects one view of one general register
package regfile_pkg;

	typedef enum logic [2:0]
	{
		sel_long,
		sel_ext_half,
		sel_lo_half,
		sel_hi_byte,
		sel_lo_byte
	} gp_sel_type;

	typedef struct packed
	{
		logic [2:0] idx;
		gp_sel_type sel;
	} operand_type;

	typedef struct packed
	{
		logic        en;
		operand_type op;
	} rd_req_type;

	typedef struct packed
	{
		logic        en;
		operand_type op;
		logic [31:0] data;
	} wr_req_type;

	typedef struct packed
	{
		logic       en;
		logic [7:0] delta;
	} stack_req_type;

endpackage : regfile_pkg

// [tb/datapath_model.sv]
// Purpose: stands in for the cpu datapath that drives the register file ports
// Assumes: one request per task call, an idle cycle between calls
// Notes: released request index and data fields show inverted values, the select is kept, so stale data is not reused
`timescale 1ns/1ps
`default_nettype none

module datapath_model
(
	// clock
	input  wire logic                      aclk,
	// requests
	output var regfile_pkg::rd_req_type    rd_a,
	output var regfile_pkg::rd_req_type    rd_b,
	output var regfile_pkg::wr_req_type    wr,
	output var regfile_pkg::stack_req_type stack_req,
	// answers
	input  wire logic [31:0]               rd_a_data,
	input  wire logic [31:0]               rd_b_data,
	input  wire logic                      rd_valid
);
	initial
	begin
		rd_a = '0;
		rd_b = '0;
		wr = '0;
		stack_req = '0;
	end

	task dp_write(input logic [2:0] i, input regfile_pkg::gp_sel_type s, input logic [31:0] d);
		@(posedge aclk);
		wr <= '{1'b1, '{i, s}, d};
		@(posedge aclk);
		wr <= '{1'b0, '{~i, s}, ~d};
		#1;
	endtask : dp_write

	task dp_read(input logic [2:0] ia, input regfile_pkg::gp_sel_type sa, input logic [2:0] ib,
		input regfile_pkg::gp_sel_type sb, output logic [31:0] a, output logic [31:0] b,
		output logic v);
		@(posedge aclk);
		rd_a <= '{1'b1, '{ia, sa}};
		rd_b <= '{1'b1, '{ib, sb}};
		@(posedge aclk);
		rd_a <= '{1'b0, '{~ia, sa}};
		rd_b <= '{1'b0, '{~ib, sb}};
		#1;
		a = rd_a_data;
		b = rd_b_data;
		v = rd_valid;
	endtask : dp_read

	task dp_stack(input logic [7:0] dl);
		@(posedge aclk);
		stack_req <= '{1'b1, dl};
		@(posedge aclk);
		stack_req <= '{1'b0, ~dl};
		#1;
	endtask : dp_stack
endmodule : datapath_model

`default_nettype wire

// [tb/cpu_general_register_file_tb_top.sv]
// Purpose: self-checking bench for the general register file
// Assumes: datapath model drives the datapath side, bench drives axi4-lite
// Notes: expected words are kept in a local shadow array
`timescale 1ns/1ps
`include "regfile_params.svh"
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end

module cpu_general_register_file_tb_top;
	logic                       aclk = 1'b0;
	logic                       aresetn = 1'b0;
	regfile_pkg::rd_req_type    rd_a;
	regfile_pkg::rd_req_type    rd_b;
	regfile_pkg::wr_req_type    wr;
	regfile_pkg::stack_req_type stack_req;
	logic [31:0]                rd_a_data, rd_b_data, stack_top_ptr;
	logic                       rd_valid, stack_loaded;
	logic                       s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0;
	logic                       s_axi_wready, s_axi_bvalid, s_axi_bready = 1'b0;
	logic                       s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid;
	logic                       s_axi_rready = 1'b0;
	logic [`ADDR_W-1:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]                s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb = '0;
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic [31:0]                m [8];
	logic [31:0]                a, b;
	logic [1:0]                 r;
	logic                       v;
	int                         errors = 0, n_compared = 0, cycles = 0;

	always #12.5 aclk = ~aclk;

	cpu_general_register_file u_dut (.aclk(aclk), .aresetn(aresetn), .rd_a(rd_a), .rd_b(rd_b),
		.rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .rd_valid(rd_valid), .wr(wr),
		.stack_req(stack_req), .stack_top_ptr(stack_top_ptr), .stack_loaded(stack_loaded),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

	datapath_model u_dp (.aclk(aclk), .rd_a(rd_a), .rd_b(rd_b), .wr(wr), .stack_req(stack_req),
		.rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .rd_valid(rd_valid));

	function automatic logic [31:0] view(input logic [31:0] w, input regfile_pkg::gp_sel_type s);
		case (s)
			regfile_pkg::sel_ext_half: view = {16'h0000, w[31:16]};
			regfile_pkg::sel_lo_half: view = {16'h0000, w[15:0]};
			regfile_pkg::sel_hi_byte: view = {24'h000000, w[15:8]};
			regfile_pkg::sel_lo_byte: view = {24'h000000, w[7:0]};
			default: view = w;
		endcase
	endfunction : view

	function automatic logic [31:0] put(input logic [31:0] w, input logic [31:0] d,
		input regfile_pkg::gp_sel_type s);
		case (s)
			regfile_pkg::sel_ext_half: put = {d[15:0], w[15:0]};
			regfile_pkg::sel_lo_half: put = {w[31:16], d[15:0]};
			regfile_pkg::sel_hi_byte: put = {w[31:16], d[7:0], w[7:0]};
			regfile_pkg::sel_lo_byte: put = {w[31:8], d[7:0]};
			default: put = d;
		endcase
	endfunction : put

	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task do_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
	endtask : do_reset

	task axi_wr(input logic [5:0] ad, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= ad;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [5:0] ad, output logic [31:0] d, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= ad;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			report_and_stop;
		end
	end

	initial
	begin
		do_reset;
		`CHK("stack_loaded", 1'b0, stack_loaded)
		for (int i = 0; i < 8; i++)
		begin
			m[i] = 32'h8765_4321 ^ (i * 32'h0101_0101);
			u_dp.dp_write(i[2:0], regfile_pkg::sel_long, m[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			u_dp.dp_read(i[2:0], regfile_pkg::sel_long, 3'(7 - i), regfile_pkg::sel_lo_byte,
				a, b, v);
			`CHK("long", m[i], a)
			`CHK("other", view(m[7 - i], regfile_pkg::sel_lo_byte), b)
			`CHK("rd_valid", 1'b1, v)
		end
		`CHK("stack_ptr", m[7], stack_top_ptr)
		`CHK("stack_loaded", 1'b1, stack_loaded)
		for (int k = 1; k < 5; k++)
		begin
			u_dp.dp_write(3'h3, regfile_pkg::gp_sel_type'(k), 32'hDEAD_0000 | (k * 32'h1357));
			m[3] = put(m[3], 32'hDEAD_0000 | (k * 32'h1357), regfile_pkg::gp_sel_type'(k));
			u_dp.dp_read(3'h3, regfile_pkg::sel_long, 3'h3, regfile_pkg::gp_sel_type'(k), a, b, v);
			`CHK("merged", m[3], a)
			`CHK("view", view(m[3], regfile_pkg::gp_sel_type'(k)), b)
		end
		u_dp.dp_stack(8'hFC);
		m[7] = m[7] + 32'hFFFF_FFFC;
		`CHK("stack_dec", m[7], stack_top_ptr)
		u_dp.dp_stack(8'h08);
		m[7] = m[7] + 32'h0000_0008;
		`CHK("stack_inc", m[7], stack_top_ptr)
		axi_wr(6'h08, 32'h0000_00CC, 4'h1, r);
		m[2][7:0] = 8'hCC;
		`CHK("bresp", `RESP_OKAY, r)
		u_dp.dp_read(3'h2, regfile_pkg::sel_long, 3'h7, regfile_pkg::sel_long, a, b, v);
		`CHK("strb_word", m[2], a)
		axi_rd(6'h1C, a, r);
		`CHK("bus_stack", m[7], a)
		axi_rd(`OFS_STATUS, a, r);
		`CHK("status", 32'h0000_0001, a)
		axi_rd(6'h28, a, r);
		`CHK("rresp_unmapped", `RESP_SLVERR, r)
		`CHK("rdata_unmapped", 32'h0000_0000, a)
		axi_wr(6'h2C, 32'hFFFF_FFFF, 4'hF, r);
		`CHK("bresp_unmapped", `RESP_SLVERR, r)
		axi_wr(`OFS_STATUS, 32'h0000_0000, 4'hF, r);
		`CHK("bresp_status", `RESP_OKAY, r)
		fork
			axi_wr(6'h0C, 32'h0000_0042, 4'h1, r);
			begin
				@(posedge aclk);
				u_dp.dp_write(3'h3, regfile_pkg::sel_long, 32'hA5A5_5A5A);
			end
		join
		m[3] = 32'hA5A5_5A42;
		`CHK("bresp_clash", `RESP_OKAY, r)
		axi_rd(6'h0C, a, r);
		`CHK("clash_word", m[3], a)
		`CHK("rresp_gp", `RESP_OKAY, r)
		axi_wr(`OFS_CTRL, 32'h0000_0001, 4'hF, r);
		`CHK("bresp_ctrl", `RESP_OKAY, r)
		axi_rd(`OFS_CTRL, a, r);
		`CHK("lock_set", 32'h0000_0001, a)
		axi_wr(6'h00, 32'h1234_5678, 4'hF, r);
		`CHK("bresp_locked", `RESP_SLVERR, r)
		axi_rd(6'h00, a, r);
		`CHK("locked_kept", m[0], a)
		do_reset;
		`CHK("loaded_again", 1'b0, stack_loaded)
		u_dp.dp_read(3'h3, regfile_pkg::sel_long, 3'h7, regfile_pkg::sel_long, a, b, v);
		`CHK("kept3", m[3], a)
		`CHK("kept7", m[7], b)
		axi_rd(`OFS_CTRL, a, r);
		`CHK("lock_reset", 32'h0000_0000, a)
		report_and_stop;
	end
endmodule : cpu_general_register_file_tb_top

`default_nettype wire
